// ---- rtl/sbt_timer.sv ----
`timescale 1ns/100ps
`include "sbt_defs.svh"

// Notes on behaviour
// - 16-bit up counter, byte writes load directly
// - Source bit 0 instruction clock, 1 external
// - Oscillator bit picks pin or crystal clock
// - Prescaler divides selected clock by 1/2/4/8
// - Prescaler hidden, cleared by counter writes
// - External mode counts rising edges, then prescales
// - Sync bit 0 synchronises, 1 bypasses
// - Falling edge needed before first counted rise
// - Oscillator enable turns crystal on, also sleeping
// - Crystal usable only in LP or internal mode
// - Oscillator on forces pin reads 1 and 0
// - Async external counting survives sleep, wakes on overflow
// - Mode switch may drop or add one count
// - Gate from comparator or gate pin
// - Count tick offered to comparator block
// - Prescale code 00/01/10/11 is 1/2/4/8
// - Timer-on bit 0 stops counting, ignores gate
// - Rollover sets sticky overflow flag
// - Gate enable counts only during active gate level

module sbt_timer (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RESETN_I,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Count and gate sources
  input wire logic EXTERNAL_COUNT_INPUT_I,
  input wire logic LOW_POWER_CRYSTAL_CLOCK_I,
  input wire logic GATE_INPUT_PIN_I,
  input wire logic CMP_OUT_I,
  // System state
  input wire logic SLEEP_I,
  input wire logic SYS_LP_OR_INTOSC_I,
  // Oscillator pin views from the port logic
  input wire logic OSC_PIN_A_DIRECTION_I,
  input wire logic OSC_PIN_B_DIRECTION_I,
  input wire logic OSC_PIN_A_DATA_I,
  input wire logic OSC_PIN_B_DATA_I,
  // Oscillator and pin read values
  output logic LOW_POWER_OSC_ENABLE_O,
  output logic OSC_PIN_A_DIRECTION_O,
  output logic OSC_PIN_B_DIRECTION_O,
  output logic OSC_PIN_A_DATA_O,
  output logic OSC_PIN_B_DATA_O,
  // Events and status
  output logic OVERFLOW_FLAG_O,
  output logic WAKE_O,
  output logic COUNT_TICK_O
);

  // Control bits
  logic [7:0] ctrl; // Control register
  logic [7:0] next_ctrl;
  logic gate_source; // 1 selects comparator as gate
  logic next_gate_source;
  logic timer_on;
  logic clock_source_select;
  logic sync_bypass;
  logic low_power_osc_enable;
  sbt_pkg::sbt_ps_t prescale_select;
  logic gate_enable;
  logic gate_invert;

  // Bus decode
  logic bus_req; // Request present, not yet answered
  logic bus_wr; // Write takes effect at this edge
  logic next_ack;
  logic [31:0] next_dat;
  logic wr_lo; // Low count byte written
  logic wr_hi; // High count byte written
  logic wr_ctrl;
  logic wr_stat;
  logic wr_gate;
  logic cnt_write; // Either count byte written

  // Front end
  sbt_pkg::sbt_src_e src; // Selected source
  logic src_level; // Raw external level chosen
  logic sync_a; // Synchroniser stage one
  logic sync_b; // Synchroniser stage two
  logic prev; // Previous selected level
  logic armed; // Falling edge seen since last disarm
  logic next_sync_a;
  logic next_sync_b;
  logic next_prev;
  logic next_armed;
  logic sel_level; // Level used for edge detect
  logic rise;
  logic fall;
  logic [1:0] q_cnt; // Instruction clock phase
  logic [1:0] next_q_cnt;
  logic instr_tick;
  logic raw_tick;
  logic gate_active;
  logic count_allow;
  logic ps_tick; // Prescaled count enable

  // Counter and events
  logic [15:0] count; // Live counter
  logic [15:0] next_count;
  logic overflow_flag;
  logic next_overflow_flag;
  logic rollover;
  logic next_wake;
  logic next_tick_out;
  logic next_dir_a;
  logic next_dir_b;
  logic next_data_a;
  logic next_data_b;

  // Field split of the control register
  assign timer_on = ctrl[`SBT_CTRL_ON];
  assign clock_source_select = ctrl[`SBT_CTRL_CS];
  assign sync_bypass = ctrl[`SBT_CTRL_SYNC];
  assign low_power_osc_enable = ctrl[`SBT_CTRL_OSCEN];
  assign prescale_select = ctrl[`SBT_CTRL_PS_HI:`SBT_CTRL_PS_LO];
  assign gate_enable = ctrl[`SBT_CTRL_GE];
  assign gate_invert = ctrl[`SBT_CTRL_GINV];
  // Bus strobes; the answer comes one cycle after the request
  assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  // Writes act on the edge where ack is high, as the master expects
  assign bus_wr = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O & WB_SEL_I[0];
  assign wr_lo = bus_wr & (WB_ADR_I == `SBT_ADR_CNT_LO);
  assign wr_hi = bus_wr & (WB_ADR_I == `SBT_ADR_CNT_HI);
  assign wr_ctrl = bus_wr & (WB_ADR_I == `SBT_ADR_CTRL);
  assign wr_stat = bus_wr & (WB_ADR_I == `SBT_ADR_STAT);
  assign wr_gate = bus_wr & (WB_ADR_I == `SBT_ADR_GATE);
  assign cnt_write = wr_lo | wr_hi;

  // Bus answer and read mux; unmapped reads return zero
  always_comb
  begin
    next_ack = bus_req;
    next_dat = WB_DAT_O;
    if (bus_req)
    begin
      unique case (WB_ADR_I)
        `SBT_ADR_CNT_LO: next_dat = {24'h000000, count[7:0]};
        `SBT_ADR_CNT_HI: next_dat = {24'h000000, count[15:8]};
        `SBT_ADR_CTRL: next_dat = {24'h000000, ctrl};
        `SBT_ADR_STAT: next_dat = {30'h00000000, armed, overflow_flag};
        `SBT_ADR_GATE: next_dat = {31'h00000000, gate_source};
        default: next_dat = 32'h00000000;
      endcase
    end
  end

  // Bus registers
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESETN_I)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end
    else
    begin
      WB_ACK_O <= next_ack;
      WB_DAT_O <= next_dat;
    end
  end

  // Control and gate configuration next values
  always_comb
  begin
    next_ctrl = ctrl;
    next_gate_source = gate_source;
    if (wr_ctrl)
    begin
      next_ctrl = WB_DAT_I[7:0];
    end
    if (wr_gate)
    begin
      next_gate_source = WB_DAT_I[`SBT_GATE_SRC];
    end
  end

  // Control registers
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESETN_I)
    begin
      ctrl <= `SBT_CTRL_RST;
      gate_source <= `SBT_GATE_RST;
    end
    else
    begin
      ctrl <= next_ctrl;
      gate_source <= next_gate_source;
    end
  end

  // Source choice; the crystal only counts when the system oscillator allows it
  always_comb
  begin
    if (!clock_source_select)
    begin
      src = sbt_pkg::SBT_SRC_INSTR;
    end
    else if (low_power_osc_enable && SYS_LP_OR_INTOSC_I)
    begin
      src = sbt_pkg::SBT_SRC_LPOSC;
    end
    else
    begin
      src = sbt_pkg::SBT_SRC_PIN;
    end
  end
  assign src_level = (src == sbt_pkg::SBT_SRC_LPOSC) ? LOW_POWER_CRYSTAL_CLOCK_I : EXTERNAL_COUNT_INPUT_I;
  // Sync path sees the second flop, async path the raw level; flipping
  // the bypass bit jumps between sample ages, so one edge may be lost or doubled.
  assign sel_level = sync_bypass ? src_level : sync_b;
  assign rise = sel_level & ~prev;
  assign fall = ~sel_level & prev;
  assign instr_tick = (q_cnt == `SBT_INSTR_LAST); // Fosc/4

  // Gate: the invert bit makes the gate active high
  assign gate_active = ~((gate_source ? CMP_OUT_I : GATE_INPUT_PIN_I) ^ gate_invert);

  // Counting needs the timer on; during sleep only async external runs
  assign count_allow = timer_on
    & (~gate_enable | gate_active)
    & (~SLEEP_I | (clock_source_select & sync_bypass));

  // Raw tick per source; external rises count only once armed
  always_comb
  begin
    unique case (src)
      sbt_pkg::SBT_SRC_INSTR: raw_tick = instr_tick;
      sbt_pkg::SBT_SRC_PIN: raw_tick = rise & armed;
      sbt_pkg::SBT_SRC_LPOSC: raw_tick = rise & armed;
      default: raw_tick = 1'b0;
    endcase
  end

  // Front-end next values
  always_comb
  begin
    next_sync_a = src_level;
    next_sync_b = sync_a;
    next_prev = sel_level;
    next_armed = armed;
    next_q_cnt = q_cnt + 2'h1;
    if (cnt_write || !timer_on)
    begin
      next_armed = 1'b0;
    end
    else if (fall)
    begin
      next_armed = 1'b1;
    end
  end

  // Front-end registers
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESETN_I)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
      armed <= 1'b0;
      q_cnt <= 2'h0;
    end
    else
    begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      prev <= next_prev;
      armed <= next_armed;
      q_cnt <= next_q_cnt;
    end
  end

  // Prescaler ahead of the counter
  sbt_prescaler #(
    .PS_W(3)
  ) u_prescaler (
    .clk_i(REF_CLK_I),
    .resetn_i(RESETN_I),
    .clear_i(cnt_write),
    .sel_i(prescale_select),
    .tick_i(raw_tick & count_allow),
    .tick_o(ps_tick)
  );
  assign rollover = ps_tick & (count == `SBT_CNT_MAX) & ~cnt_write;
  // Counter, flag and output next values
  always_comb
  begin
    next_count = count;
    next_overflow_flag = overflow_flag;
    if (cnt_write)
    begin
      // A write beats a coincident increment
      if (wr_lo)
      begin
        next_count[7:0] = WB_DAT_I[7:0];
      end
      if (wr_hi)
      begin
        next_count[15:8] = WB_DAT_I[7:0];
      end
    end
    else if (ps_tick)
    begin
      next_count = count + 16'h0001;
    end
    if (wr_stat && WB_DAT_I[`SBT_STAT_OVF])
    begin
      next_overflow_flag = 1'b0; // Write one to clear
    end
    if (rollover)
    begin
      next_overflow_flag = 1'b1;
    end
    next_wake = rollover & SLEEP_I;
    next_tick_out = ps_tick;
    // Oscillator pins read as inputs holding zero while the crystal is on
    next_dir_a = low_power_osc_enable | OSC_PIN_A_DIRECTION_I;
    next_dir_b = low_power_osc_enable | OSC_PIN_B_DIRECTION_I;
    next_data_a = ~low_power_osc_enable & OSC_PIN_A_DATA_I;
    next_data_b = ~low_power_osc_enable & OSC_PIN_B_DATA_I;
  end

  // Counter, flag and output registers
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESETN_I)
    begin
      count <= `SBT_CNT_RST;
      overflow_flag <= 1'b0;
      WAKE_O <= 1'b0;
      COUNT_TICK_O <= 1'b0;
      OSC_PIN_A_DIRECTION_O <= 1'b0;
      OSC_PIN_B_DIRECTION_O <= 1'b0;
      OSC_PIN_A_DATA_O <= 1'b0;
      OSC_PIN_B_DATA_O <= 1'b0;
    end
    else
    begin
      count <= next_count;
      overflow_flag <= next_overflow_flag;
      WAKE_O <= next_wake;
      COUNT_TICK_O <= next_tick_out;
      OSC_PIN_A_DIRECTION_O <= next_dir_a;
      OSC_PIN_B_DIRECTION_O <= next_dir_b;
      OSC_PIN_A_DATA_O <= next_data_a;
      OSC_PIN_B_DATA_O <= next_data_b;
    end
  end
  // The crystal stays on in sleep; it is never gated by SLEEP_I
  assign LOW_POWER_OSC_ENABLE_O = low_power_osc_enable;
  assign OVERFLOW_FLAG_O = overflow_flag;

endmodule : sbt_timer

// ---- pkg/sbt_defs.svh ----
`ifndef SBT_DEFS_SVH
`define SBT_DEFS_SVH

// Register byte offsets on the bus
`define SBT_ADR_CNT_LO 8'h00
`define SBT_ADR_CNT_HI 8'h04
`define SBT_ADR_CTRL 8'h08
`define SBT_ADR_STAT 8'h0c
`define SBT_ADR_GATE 8'h10

// Control register field positions
`define SBT_CTRL_ON 0
`define SBT_CTRL_CS 1
`define SBT_CTRL_SYNC 2
`define SBT_CTRL_OSCEN 3
`define SBT_CTRL_PS_LO 4
`define SBT_CTRL_PS_HI 5
`define SBT_CTRL_GE 6
`define SBT_CTRL_GINV 7

// Status register field positions
`define SBT_STAT_OVF 0
`define SBT_STAT_ARMED 1

// Gate configuration field position
`define SBT_GATE_SRC 0

// Reset values
`define SBT_CTRL_RST 8'h00
`define SBT_GATE_RST 1'b0
`define SBT_CNT_RST 16'h0000

// Counter limits and timing
`define SBT_CNT_MAX 16'hffff
`define SBT_INSTR_LAST 2'h3

`endif

// ---- pkg/sbt_pkg.sv ----
package sbt_pkg;

  // Which clock feeds the prescaler
  typedef enum logic [1:0] {
    SBT_SRC_INSTR = 2'b00,
    SBT_SRC_PIN = 2'b01,
    SBT_SRC_LPOSC = 2'b10
  } sbt_src_e;

  // Prescale ratio code
  typedef logic [1:0] sbt_ps_t;

endpackage : sbt_pkg

// ---- rtl/sbt_prescaler.sv ----
`timescale 1ns/100ps
`include "sbt_defs.svh"

module sbt_prescaler #(
  parameter int PS_W = 3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Control
  input wire logic clear_i,
  input wire sbt_pkg::sbt_ps_t sel_i,
  // Ticks
  input wire logic tick_i,
  output logic tick_o
);

  logic [PS_W-1:0] cnt; // Hidden from software by design
  logic [PS_W-1:0] next_cnt;
  logic [PS_W-1:0] mask; // Low bits that must all be one

  // Ratio decode: 1, 2, 4 or 8
  always_comb
  begin
    unique case (sel_i)
      2'b00: mask = PS_W'(0);
      2'b01: mask = PS_W'(1);
      2'b10: mask = PS_W'(3);
      2'b11: mask = PS_W'(7);
    endcase
  end

  // Output tick on the last input tick of each group
  assign tick_o = tick_i & ((cnt & mask) == mask);

  // Next value: a counter write clears the prescaler
  always_comb
  begin
    next_cnt = cnt;
    if (clear_i)
    begin
      next_cnt = '0;
    end
    else if (tick_i)
    begin
      next_cnt = cnt + PS_W'(1);
    end
  end

  // Register
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      cnt <= '0;
    end
    else
    begin
      cnt <= next_cnt;
    end
  end

endmodule : sbt_prescaler

// ---- sim/sbt_timer_props.sv ----
`timescale 1ns/100ps
// Port-level checks of the gated timer
module sbt_timer_props (
  // Clock, reset and bus
  input wire logic REF_CLK_I,
  input wire logic RESETN_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic WB_ACK_O,
  // System and pin views
  input wire logic SLEEP_I,
  input wire logic OSC_PIN_A_DIRECTION_I,
  input wire logic LOW_POWER_OSC_ENABLE_O,
  input wire logic OSC_PIN_A_DIRECTION_O,
  input wire logic OSC_PIN_B_DIRECTION_O,
  input wire logic OSC_PIN_A_DATA_O,
  input wire logic OSC_PIN_B_DATA_O,
  // Events
  input wire logic OVERFLOW_FLAG_O,
  input wire logic WAKE_O,
  input wire logic COUNT_TICK_O
);
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RESETN_I);
  bus_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("request not answered");
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  osc_dir_a: assert property (LOW_POWER_OSC_ENABLE_O && $past(LOW_POWER_OSC_ENABLE_O)
    |-> OSC_PIN_A_DIRECTION_O && OSC_PIN_B_DIRECTION_O) else $error("direction not forced");
  osc_data_a: assert property (LOW_POWER_OSC_ENABLE_O && $past(LOW_POWER_OSC_ENABLE_O)
    |-> !OSC_PIN_A_DATA_O && !OSC_PIN_B_DATA_O) else $error("data not forced");
  // Without the oscillator the port view passes through one register
  pin_pass_a: assert property ($past(RESETN_I) && !LOW_POWER_OSC_ENABLE_O && !$past(LOW_POWER_OSC_ENABLE_O)
    |-> OSC_PIN_A_DIRECTION_O == $past(OSC_PIN_A_DIRECTION_I)) else $error("pin view wrong");
  wake_sleep_a: assert property (WAKE_O |-> OVERFLOW_FLAG_O && $past(SLEEP_I))
    else $error("wake without sleep rollover");
  // Only a write of one to status may drop the sticky flag
  flag_clear_a: assert property ($fell(OVERFLOW_FLAG_O)
    |-> $past(WB_ACK_O && WB_WE_I && WB_ADR_I == 8'h0c && WB_DAT_I[0])) else $error("flag lost");
  flag_set_a: assert property ($rose(OVERFLOW_FLAG_O) |-> ##[0:1] COUNT_TICK_O)
    else $error("flag without increment");
  tick_single_a: assert property (COUNT_TICK_O |=> !COUNT_TICK_O)
    else $error("tick wider than one cycle");
  wake_c: cover property (WAKE_O);
  flag_c: cover property ($rose(OVERFLOW_FLAG_O));
  osc_c: cover property ($rose(LOW_POWER_OSC_ENABLE_O));
endmodule : sbt_timer_props

bind sbt_timer sbt_timer_props u_sbt_timer_props (.REF_CLK_I, .RESETN_I, .WB_CYC_I, .WB_STB_I, .WB_WE_I,
  .WB_ADR_I, .WB_DAT_I, .WB_ACK_O, .SLEEP_I, .OSC_PIN_A_DIRECTION_I, .LOW_POWER_OSC_ENABLE_O,
  .OSC_PIN_A_DIRECTION_O, .OSC_PIN_B_DIRECTION_O, .OSC_PIN_A_DATA_O, .OSC_PIN_B_DATA_O,
  .OVERFLOW_FLAG_O, .WAKE_O, .COUNT_TICK_O);

// ---- sim/sbt_ext_src.sv ----
`timescale 1ns/100ps
// Far side: a count pin pulsed on demand and a crystal clock
module sbt_ext_src (
  // Clock and crystal enable
  input wire logic clk_i,
  input wire logic osc_en_i,
  // Count sources
  output logic ext_o,
  output logic xtal_o
);
  logic [1:0] div; // Crystal half-period count, shortened to keep runs brief
  initial
  begin
    ext_o = 1'b0;
    xtal_o = 1'b0;
    div = 2'h0;
  end
  // Crystal runs only while enabled and idles low otherwise
  always @(posedge clk_i)
  begin
    div <= div + 2'h1;
    if (!osc_en_i)
      xtal_o <= 1'b0;
    else if (div == 2'h3)
      xtal_o <= ~xtal_o;
  end
  // Whole pulses; each level held for half cycles
  task automatic pulses(input int n, input int half);
    repeat (n)
    begin
      @(posedge clk_i);
      ext_o <= 1'b1;
      repeat (half) @(posedge clk_i);
      ext_o <= 1'b0;
      repeat (half - 1) @(posedge clk_i);
    end
  endtask : pulses
endmodule : sbt_ext_src

// ---- sim/sbt_timer_bench.sv ----
`timescale 1ns/100ps
// Register-level tests of the gated timer
module sbt_timer_bench;
  logic clk, rst_n, cyc, stb, we, gin, cmp, sleep, sys_lp, pin_in; // Driven inputs
  logic [7:0] adr, r; // Address and last byte read
  logic [3:0] sel;
  logic [31:0] dat_i, dat_o;
  logic ack, ext, xtal, osc_en, dira, dirb, data_a, data_b, ovf, wake, tick;
  logic [15:0] c; // Last count read
  int bad_count, n_compared, k, t0, n_tick;

  sbt_timer u_sbt_timer (.REF_CLK_I(clk), .RESETN_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .EXTERNAL_COUNT_INPUT_I(ext), .LOW_POWER_CRYSTAL_CLOCK_I(xtal), .GATE_INPUT_PIN_I(gin),
    .CMP_OUT_I(cmp), .SLEEP_I(sleep), .SYS_LP_OR_INTOSC_I(sys_lp), .OSC_PIN_A_DIRECTION_I(pin_in),
    .OSC_PIN_B_DIRECTION_I(pin_in), .OSC_PIN_A_DATA_I(~pin_in), .OSC_PIN_B_DATA_I(~pin_in),
    .LOW_POWER_OSC_ENABLE_O(osc_en), .OSC_PIN_A_DIRECTION_O(dira), .OSC_PIN_B_DIRECTION_O(dirb),
    .OSC_PIN_A_DATA_O(data_a), .OSC_PIN_B_DATA_O(data_b), .OVERFLOW_FLAG_O(ovf), .WAKE_O(wake),
    .COUNT_TICK_O(tick));
  sbt_ext_src u_sbt_ext_src (.clk_i(clk), .osc_en_i(osc_en), .ext_o(ext), .xtal_o(xtal));

  // Tick pulses offered to the comparator side, counted here
  always @(posedge clk)
    n_tick <= rst_n ? n_tick + int'(tick === 1'b1) : 0;

  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e)
    begin
      $display("FAIL %s expected %h seen %h", nm, e, s);
      bad_count++;
    end
  endtask : chk

  // One classic cycle; waits for ack, a lost answer ends the run
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50)
    begin
      bad_count++;
      report_and_stop;
    end
  endtask : wb

  // Read both bytes; callers stop the timer first so they agree
  task automatic cnt;
    wb(1'b0, 8'h00, 8'h00);
    c[7:0] = r;
    wb(1'b0, 8'h04, 8'h00);
    c[15:8] = r;
  endtask : cnt

  // Stop and zero the counter
  task automatic clr;
    wb(1'b1, 8'h08, 8'h00);
    wb(1'b1, 8'h04, 8'h00);
    wb(1'b1, 8'h00, 8'h00);
  endtask : clr

  // Run with a control value for n cycles, then stop and read
  task automatic run(input logic [7:0] ctl, input int n);
    wb(1'b1, 8'h08, ctl);
    repeat (n) @(posedge clk);
    wb(1'b1, 8'h08, 8'h00);
    cnt;
  endtask : run

  // Count within a window; the tick phase is free-running
  task automatic rng(input int lo, input int hi);
    chk("count", 16'(c >= lo && c <= hi), 16'h1);
  endtask : rng

  initial
  begin
    {cyc, stb, we, gin, cmp, sleep, sys_lp, pin_in} = 8'h00;
    adr = 8'h00;
    sel = 4'h1;
    dat_i = 32'h0;
    bad_count = 0;
    n_compared = 0;
    rst_n = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, 8'h08, 8'h00);
    chk("ctrl", r, 16'h0);
    wb(1'b0, 8'h00, 8'h00);
    chk("count low", r, 16'h0);
    wb(1'b0, 8'h14, 8'h00);
    chk("unmapped", r, 16'h0);
    $display("test reset done");
    for (k = 0; k < 4; k++)
    begin
      clr;
      run({2'b00, k[1:0], 4'h1}, 256);
      rng((64 >> k) - 1, (64 >> k) + 2);
    end
    k = c;
    repeat (40) @(posedge clk);
    cnt;
    chk("stopped", c, 16'(k));
    $display("test prescale done");
    clr;
    wb(1'b1, 8'h04, 8'hff);
    wb(1'b1, 8'h00, 8'hfe);
    run(8'h01, 24);
    rng(3, 6);
    chk("flag", ovf, 16'h1);
    wb(1'b1, 8'h0c, 8'h01);
    wb(1'b0, 8'h0c, 8'h00);
    chk("flag clear", r[0], 16'h0);
    $display("test rollover done");
    for (k = 0; k < 2; k++)
    begin
      clr;
      wb(1'b1, 8'h08, (k == 0) ? 8'h03 : 8'h07);
      t0 = n_tick;
      u_sbt_ext_src.pulses(5, 4);
      repeat (8) @(posedge clk);
      wb(1'b1, 8'h08, 8'h00);
      cnt;
      chk("pin count", c, 16'h4);
      chk("ticks", 16'(n_tick - t0), 16'h4);
    end
    $display("test external done");
    clr;
    gin <= 1'b1;
    wb(1'b1, 8'h08, 8'h41);
    repeat (64) @(posedge clk);
    wb(1'b0, 8'h00, 8'h00);
    chk("gated", r, 16'h0);
    gin <= 1'b0;
    repeat (64) @(posedge clk);
    wb(1'b1, 8'h08, 8'h00);
    cnt;
    rng(14, 19);
    clr;
    wb(1'b1, 8'h10, 8'h01);
    cmp <= 1'b1;
    run(8'hc1, 64);
    rng(14, 18);
    $display("test gate done");
    clr;
    chk("dir a off", dira, 16'h0);
    chk("data a off", data_a, 16'h1);
    wb(1'b1, 8'h08, 8'h08);
    repeat (2) @(posedge clk);
    chk("osc enable", osc_en, 16'h1);
    chk("dir a", dira, 16'h1);
    chk("data b", data_b, 16'h0);
    chk("dir b", dirb, 16'h1);
    chk("data a", data_a, 16'h0);
    sys_lp <= 1'b1;
    wb(1'b1, 8'h04, 8'hff);
    wb(1'b1, 8'h00, 8'hf0);
    sleep <= 1'b1;
    wb(1'b1, 8'h08, 8'h0f);
    for (k = 0; k < 2000 && wake !== 1'b1; k++) @(posedge clk);
    chk("wake", wake, 16'h1);
    sleep <= 1'b0;
    $display("test sleep done");
    report_and_stop;
  end
endmodule : sbt_timer_bench
